// ---- sras_defines.vh ----
// Constants for the register-access sequencer of the serial slave.
// Assumes inclusion by bare name from the tracker and sequencer design files.
`ifndef SRAS_DEFINES_VH
`define SRAS_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define SRAS_A_CFG_A 7'h00
`define SRAS_A_CFG_B 7'h01
`define SRAS_A_MAKER_LO 7'h0C
`define SRAS_A_MAKER_HI 7'h0D
`define SRAS_A_LOOP_CNT 7'h0E
`define SRAS_A_XFER 7'h0F
`define SRAS_A_CFG_C 7'h10
`define SRAS_A_STAT_A 7'h11
`define SRAS_A_CODE_LO 7'h29
`define SRAS_A_CODE_HI 7'h2A
`define SRAS_A_TRIM_LO 7'h2B
`define SRAS_A_TRIM_MID 7'h2C
`define SRAS_A_TRIM_HI 7'h2D
`define SRAS_A_TOP 7'h4B
`define SRAS_A_BOTTOM 7'h00

// ****************************************
// Field positions
// ****************************************
`define SRAS_B_ADDR_ASC 5
`define SRAS_B_SINGLE_INSTR 7
`define SRAS_B_SHORT_INSTR 3
`define SRAS_B_PARTIAL 2
`define SRAS_B_RETAIN 2

// ****************************************
// Reset and fixed values
// ****************************************
`define SRAS_RST_CFG_A 8'h00
`define SRAS_RST_CFG_B 8'h08
`define SRAS_RST_BYTE 8'h00
`define SRAS_RST_CODE 16'h0000
`define SRAS_RST_TRIM 24'h00_0000
`define SRAS_CFG_C_VAL 8'h20
`define SRAS_MAKER_ID_DFLT 16'h5A3C

// ****************************************
// Frame geometry and multibyte groups
// ****************************************
`define SRAS_INSTR_SHORT 5'h08
`define SRAS_INSTR_LONG 5'h10
`define SRAS_LAST_BIT 5'h07
`define SRAS_SZ_ONE 2'h1
`define SRAS_SZ_TWO 2'h2
`define SRAS_SZ_THREE 2'h3
`define SRAS_SEL_MAKER 2'h0
`define SRAS_SEL_CODE 2'h1
`define SRAS_SEL_TRIM 2'h2

`endif

// ---- sras_sync.v ----
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are quasi-static relative to clk.
`timescale 1ns/1ps
module sras_sync #(
    parameter W = 3
)(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Asynchronous in, synchronous out
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg meta_ff;
            reg sync_ff;
            always @(posedge clk)
            begin
                if (!rst_n)
                begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= din[i];
                    sync_ff <= meta_ff;
                end
            end
            assign dout[i] = sync_ff;
        end
    endgenerate
endmodule

// ---- sras_mb_tracker.v ----
// Tracks byte sequences that hit multibyte registers and decides
// whether a complete, correctly ordered transfer happened.
// Assumes one byte_valid pulse per completed data byte.
`timescale 1ns/1ps
`include "sras_defines.vh"
module sras_mb_tracker (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Byte event from the sequencer
    input wire byte_valid,
    input wire byte_wr,
    input wire [7:0] byte_data,
    input wire [1:0] mb_sel,
    input wire [1:0] mb_pos,
    input wire [1:0] mb_size,
    input wire mb_lock,
    input wire addr_asc,
    input wire frame_end,
    // Results
    output reg commit,
    output reg [1:0] commit_sel,
    output wire [23:0] commit_data,
    output reg partial
);
    reg [1:0] cnt_ff;
    reg [1:0] sel_ff;
    reg [23:0] buf_ff;

    wire [1:0] last = mb_size - `SRAS_SZ_ONE;
    wire [1:0] exp_pos = addr_asc ? cnt_ff : last - cnt_ff;
    wire [1:0] first = addr_asc ? 2'h0 : last;
    wire is_mb = (mb_size != `SRAS_SZ_ONE);
    // Order of bytes follows the direction setting
    wire cont = (cnt_ff != 2'h0) & is_mb & (mb_sel == sel_ff) &
                (mb_pos == exp_pos);
    // Host must open on the first byte of the register
    wire fresh = is_mb & (mb_pos == first);
    wire take = cont | fresh;
    wire [1:0] cnt_inc = cont ? cnt_ff + 2'h1 : 2'h1;
    wire done = take & (cnt_inc == mb_size);

    // ****************************************
    // Staging lanes, one per byte position
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_lane
            always @(posedge clk)
            begin
                if (!rst_n)
                    buf_ff[i*8 +: 8] <= `SRAS_RST_BYTE;
                else if (byte_valid & take & (mb_pos == i))
                    buf_ff[i*8 +: 8] <= byte_data;
            end
        end
    endgenerate
    assign commit_data = buf_ff;

    // ****************************************
    // Sequence decision
    // ****************************************
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 2'h0;
            sel_ff <= 2'h0;
            commit <= 1'b0;
            commit_sel <= 2'h0;
            partial <= 1'b0;
        end
        else
        begin
            commit <= 1'b0;
            partial <= 1'b0;
            if (byte_valid)
            begin
                // Broken or mid-register start: no update, flag it
                if (((cnt_ff != 2'h0) & !cont) | (is_mb & !take))
                    partial <= 1'b1;
                if (done)
                begin
                    cnt_ff <= 2'h0;
                    if (byte_wr & addr_asc & mb_lock)
                        partial <= 1'b1;
                    else if (byte_wr)
                    begin
                        commit <= 1'b1;
                        commit_sel <= mb_sel;
                    end
                end
                else if (take)
                begin
                    cnt_ff <= cnt_inc;
                    sel_ff <= mb_sel;
                end
                else
                    cnt_ff <= 2'h0;
            end
            else if (frame_end)
            begin
                // Register only partly transferred is dropped
                if (cnt_ff != 2'h0)
                    partial <= 1'b1;
                cnt_ff <= 2'h0;
            end
        end
    end
endmodule

// ---- sras_seq.v ----
// Register-access sequencer: serial slave front end, register file,
// address stepping, looping and multibyte protection.
// Assumes SPI mode 0 or 3 from an outside host; pins are asynchronous
// to clk and sclk is much slower than clk.
`timescale 1ns/1ps
`include "sras_defines.vh"
module sras_seq #(
    // Arbitrary identification value
    parameter [15:0] MAKER_ID = `SRAS_MAKER_ID_DFLT
)(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Serial pins
    input wire cs_n,
    input wire sclk,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe_n,
    // Register contents driving the converter
    output reg [15:0] channel_code_word,
    output reg [23:0] trim_word,
    output reg partial_access_flag
);
    localparam ST_IDLE = 2'h0;
    localparam ST_INSTR = 2'h1;
    localparam ST_DATA = 2'h2;

    // ****************************************
    // Pin synchronisation and edge detection
    // ****************************************
    // Select is synced inverted so the reset value of the chain matches
    // an idle pin and no false frame edge follows reset
    wire cs_act_s;
    wire cs_n_s = ~cs_act_s;
    wire sclk_s;
    wire sdi_s;
    reg sclk_d_ff;
    reg cs_d_ff;

    sras_sync #(.W(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({~cs_n, sclk, sdi}),
        .dout({cs_act_s, sclk_s, sdi_s})
    );

    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;
    wire cs_fall = ~cs_n_s & cs_d_ff;
    wire cs_rise = cs_n_s & ~cs_d_ff;

    // ****************************************
    // State
    // ****************************************
    reg [1:0] state_ff;
    reg [4:0] bit_cnt_ff;
    reg [15:0] rx_ff;
    reg [7:0] tx_ff;
    reg rd_ff;
    reg [14:0] addr_ff;
    reg [14:0] start_ff;
    reg [7:0] byte_cnt_ff;
    reg [1:0] reg_bytes_ff;
    reg [1:0] reg_size_ff;
    reg fend_ff;
    reg [7:0] cfg_a_ff;
    reg [7:0] cfg_b_ff;
    reg [7:0] loop_byte_count_ff;
    reg [7:0] xfer_ff;

    wire addr_asc = cfg_a_ff[`SRAS_B_ADDR_ASC];
    wire single_instr = cfg_b_ff[`SRAS_B_SINGLE_INSTR];
    wire retain_loop_count = xfer_ff[`SRAS_B_RETAIN];
    wire [4:0] instr_len = cfg_b_ff[`SRAS_B_SHORT_INSTR] ?
                           `SRAS_INSTR_SHORT : `SRAS_INSTR_LONG;
    wire [15:0] nxt_rx = {rx_ff[14:0], sdi_s};
    wire instr_done = (state_ff == ST_INSTR) & sclk_rise &
                      (bit_cnt_ff == instr_len - 5'h01);
    wire byte_done = (state_ff == ST_DATA) & sclk_rise &
                     (bit_cnt_ff == `SRAS_LAST_BIT);
    // First bit is R/W, the rest the address, MSB first
    wire instr_rd = cfg_b_ff[`SRAS_B_SHORT_INSTR] ?
                    nxt_rx[7] : nxt_rx[15];
    wire [14:0] instr_addr = cfg_b_ff[`SRAS_B_SHORT_INSTR] ?
                             {8'h00, nxt_rx[6:0]} : nxt_rx[14:0];

    // ****************************************
    // Address decode helpers
    // ****************************************
    // Returns {sel, pos, size}; size one means a plain byte
    function [5:0] mb_info;
        input [14:0] a;
        begin
            mb_info = {`SRAS_SEL_MAKER, 2'h0, `SRAS_SZ_ONE};
            if (a[14:7] == 8'h00)
            begin
                case (a[6:0])
                `SRAS_A_MAKER_LO: mb_info = {`SRAS_SEL_MAKER, 2'h0,
                                             `SRAS_SZ_TWO};
                `SRAS_A_MAKER_HI: mb_info = {`SRAS_SEL_MAKER, 2'h1,
                                             `SRAS_SZ_TWO};
                `SRAS_A_CODE_LO: mb_info = {`SRAS_SEL_CODE, 2'h0,
                                            `SRAS_SZ_TWO};
                `SRAS_A_CODE_HI: mb_info = {`SRAS_SEL_CODE, 2'h1,
                                            `SRAS_SZ_TWO};
                `SRAS_A_TRIM_LO: mb_info = {`SRAS_SEL_TRIM, 2'h0,
                                            `SRAS_SZ_THREE};
                `SRAS_A_TRIM_MID: mb_info = {`SRAS_SEL_TRIM, 2'h1,
                                             `SRAS_SZ_THREE};
                `SRAS_A_TRIM_HI: mb_info = {`SRAS_SEL_TRIM, 2'h2,
                                            `SRAS_SZ_THREE};
                default: mb_info = {`SRAS_SEL_MAKER, 2'h0, `SRAS_SZ_ONE};
                endcase
            end
        end
    endfunction

    // Unmapped and upper 15-bit addresses read as zero
    function [7:0] rd_byte;
        input [14:0] a;
        begin
            rd_byte = 8'h00;
            if (a[14:7] == 8'h00)
            begin
                case (a[6:0])
                `SRAS_A_CFG_A: rd_byte = cfg_a_ff;
                `SRAS_A_CFG_B: rd_byte = cfg_b_ff;
                `SRAS_A_MAKER_LO: rd_byte = MAKER_ID[7:0];
                `SRAS_A_MAKER_HI: rd_byte = MAKER_ID[15:8];
                `SRAS_A_LOOP_CNT: rd_byte = loop_byte_count_ff;
                `SRAS_A_XFER: rd_byte = xfer_ff;
                `SRAS_A_CFG_C: rd_byte = `SRAS_CFG_C_VAL;
                `SRAS_A_STAT_A: rd_byte = {5'h00, partial_access_flag,
                                           2'h0};
                `SRAS_A_CODE_LO: rd_byte = channel_code_word[7:0];
                `SRAS_A_CODE_HI: rd_byte = channel_code_word[15:8];
                `SRAS_A_TRIM_LO: rd_byte = trim_word[7:0];
                `SRAS_A_TRIM_MID: rd_byte = trim_word[15:8];
                `SRAS_A_TRIM_HI: rd_byte = trim_word[23:16];
                default: rd_byte = 8'h00;
                endcase
            end
        end
    endfunction

    wire [5:0] cur_info = mb_info(addr_ff);
    wire [5:0] new_info = mb_info(instr_addr);
    wire loop_end = (loop_byte_count_ff != 8'h00) &
                    (byte_cnt_ff + 8'h01 == loop_byte_count_ff);

    // ****************************************
    // Next address after a data byte
    // ****************************************
    reg [14:0] nxt_addr;
    always @*
    begin
        nxt_addr = addr_ff;
        if (loop_end)
            nxt_addr = start_ff;
        else if (addr_asc)
        begin
            // Increment when set, decrement when clear
            if (addr_ff == {8'h00, `SRAS_A_TOP})
                nxt_addr = {8'h00, `SRAS_A_BOTTOM};
            else
                nxt_addr = addr_ff + 15'h0001;
        end
        else
        begin
            if (addr_ff == {8'h00, `SRAS_A_BOTTOM})
                nxt_addr = {8'h00, `SRAS_A_TOP};
            else
                nxt_addr = addr_ff - 15'h0001;
        end
    end

    wire single_back = byte_done & single_instr &
                       (reg_bytes_ff + 2'h1 == reg_size_ff);

    // ****************************************
    // Multibyte sequence tracker
    // ****************************************
    wire mb_commit;
    wire [1:0] mb_commit_sel;
    wire [23:0] mb_data;
    wire mb_partial;

    sras_mb_tracker u_mb (
        .clk(clk),
        .rst_n(rst_n),
        .byte_valid(byte_done),
        .byte_wr(~rd_ff),
        .byte_data(nxt_rx[7:0]),
        .mb_sel(cur_info[5:4]),
        .mb_pos(cur_info[3:2]),
        .mb_size(cur_info[1:0]),
        .mb_lock(cur_info[5:4] != `SRAS_SEL_MAKER),
        .addr_asc(addr_asc),
        .frame_end(fend_ff),
        .commit(mb_commit),
        .commit_sel(mb_commit_sel),
        .commit_data(mb_data),
        .partial(mb_partial)
    );

    wire wr_plain = byte_done & ~rd_ff &
                    (cur_info[1:0] == `SRAS_SZ_ONE) &
                    (addr_ff[14:7] == 8'h00);
    wire partial_clr = wr_plain & (addr_ff[6:0] == `SRAS_A_STAT_A) &
                       nxt_rx[`SRAS_B_PARTIAL];

    // ****************************************
    // Frame sequencer
    // ****************************************
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 5'h00;
            rx_ff <= 16'h0000;
            tx_ff <= 8'h00;
            rd_ff <= 1'b0;
            addr_ff <= 15'h0000;
            start_ff <= 15'h0000;
            byte_cnt_ff <= 8'h00;
            reg_bytes_ff <= 2'h0;
            reg_size_ff <= `SRAS_SZ_ONE;
            fend_ff <= 1'b0;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
        end
        else
        begin
            sclk_d_ff <= sclk_s;
            cs_d_ff <= cs_n_s;
            // Delayed so a final byte is judged before the frame end
            fend_ff <= cs_rise | single_back;
            sdo_oe_n <= ~((state_ff == ST_DATA) & rd_ff);
            if (cs_rise)
                state_ff <= ST_IDLE;
            else if (cs_fall)
            begin
                state_ff <= ST_INSTR;
                bit_cnt_ff <= 5'h00;
            end
            else if (state_ff == ST_INSTR && sclk_rise)
            begin
                rx_ff <= nxt_rx;
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                if (instr_done)
                begin
                    state_ff <= ST_DATA;
                    bit_cnt_ff <= 5'h00;
                    rd_ff <= instr_rd;
                    addr_ff <= instr_addr;
                    start_ff <= instr_addr;
                    byte_cnt_ff <= 8'h00;
                    reg_bytes_ff <= 2'h0;
                    reg_size_ff <= new_info[1:0];
                    tx_ff <= rd_byte(instr_addr);
                end
            end
            else if (state_ff == ST_DATA && sclk_rise)
            begin
                rx_ff <= nxt_rx;
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                if (byte_done)
                begin
                    bit_cnt_ff <= 5'h00;
                    addr_ff <= nxt_addr;
                    tx_ff <= rd_byte(nxt_addr);
                    reg_bytes_ff <= reg_bytes_ff + 2'h1;
                    byte_cnt_ff <= loop_end ? 8'h00 :
                                   byte_cnt_ff + 8'h01;
                    if (single_back)
                        state_ff <= ST_INSTR;
                end
            end
            else if (state_ff == ST_DATA && sclk_fall && rd_ff)
            begin
                sdo <= tx_ff[7];
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_a_ff <= `SRAS_RST_CFG_A;
            cfg_b_ff <= `SRAS_RST_CFG_B;
            loop_byte_count_ff <= `SRAS_RST_BYTE;
            xfer_ff <= `SRAS_RST_BYTE;
            channel_code_word <= `SRAS_RST_CODE;
            trim_word <= `SRAS_RST_TRIM;
            partial_access_flag <= 1'b0;
        end
        else
        begin
            // Set wins over a same-cycle clear
            partial_access_flag <= mb_partial |
                (partial_access_flag & ~partial_clr);
            if (mb_commit && mb_commit_sel == `SRAS_SEL_CODE)
                channel_code_word <= mb_data[15:0];
            if (mb_commit && mb_commit_sel == `SRAS_SEL_TRIM)
                trim_word <= mb_data;
            if (cs_rise && !retain_loop_count)
                loop_byte_count_ff <= `SRAS_RST_BYTE;
            else if (wr_plain && addr_ff[6:0] == `SRAS_A_LOOP_CNT)
                loop_byte_count_ff <= nxt_rx[7:0];
            if (wr_plain && addr_ff[6:0] == `SRAS_A_CFG_A)
                cfg_a_ff <= nxt_rx[7:0];
            if (wr_plain && addr_ff[6:0] == `SRAS_A_CFG_B)
                cfg_b_ff <= nxt_rx[7:0];
            if (wr_plain && addr_ff[6:0] == `SRAS_A_XFER)
                xfer_ff <= nxt_rx[7:0];
        end
    end
endmodule

// ---- sras_props.sv ----
// Checker for the register-access sequencer, watching top ports only.
// Assumes sclk idles low and is far slower than clk.
`timescale 1ns/1ps
module sras_props (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Serial pins
    input wire cs_n,
    input wire sclk,
    input wire sdi,
    input wire sdo,
    input wire sdo_oe_n,
    // Register contents
    input wire [15:0] channel_code_word,
    input wire [23:0] trim_word,
    input wire partial_access_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Read phase and idle frame shapes
    // ****************************************
    sequence s_read_start;
        !cs_n && $fell(sdo_oe_n);
    endsequence
    sequence s_idle;
        cs_n [*8];
    endsequence
    chk_oe_idle: assert property (cs_n [*6] |-> sdo_oe_n)
        else $error("sdo enabled outside a frame");
    chk_oe_hold: assert property (s_read_start |-> !sdo_oe_n [*8])
        else $error("sdo enable dropped early in a read");
    chk_idle_quiet: assert property (s_idle |-> $stable(channel_code_word)
        && $stable(trim_word) && $stable(partial_access_flag))
        else $error("state changed with no frame");
    chk_sclk_quiet: assert property (!sclk [*8] |->
        $stable(channel_code_word) && $stable(trim_word))
        else $error("multibyte register changed late");
    chk_code_frame: assert property ($changed(channel_code_word)
        |-> $past(!cs_n, 5))
        else $error("code word changed outside a frame");
    chk_trim_frame: assert property ($changed(trim_word) |-> $past(!cs_n, 5))
        else $error("trim word changed outside a frame");
    chk_sdo_fall: assert property (!sdo_oe_n && $past(!sdo_oe_n) &&
        $changed(sdo) |-> !sclk && $past(!sclk, 2))
        else $error("sdo moved away from a falling sclk");
    chk_sdo_hold: assert property (sclk [*6] |-> $stable(sdo))
        else $error("sdo moved while sclk high");
    chk_flag_clear: assert property ($fell(partial_access_flag)
        |-> $past(!cs_n, 3))
        else $error("partial flag cleared without a write");
endmodule
bind sras_seq sras_props sras_props_i (.clk, .rst_n, .cs_n, .sclk, .sdi,
    .sdo, .sdo_oe_n, .channel_code_word, .trim_word, .partial_access_flag);

// ---- sras_host.sv ----
// Serial host model: mode 0, MSB first, 125 ns sclk, framed by cs_n.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module sras_host (
    // Serial pins toward the device
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire sdo,
    input wire sdo_oe_n
);
    logic drive = 1'b0;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Released data line toggles so a stale bit is never mistaken for data
    always #8 if (!drive) sdi = ~sdi;
    task start_frame();
        drive <= 1'b1;
        cs_n <= 1'b0;
        #62.5;
    endtask
    task xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sdi <= tx[i];
            #62.5;
            rx[i] = sdo;
            sclk <= 1'b1;
            #62.5;
            sclk <= 1'b0;
        end
    endtask
    task end_frame();
        #62.5;
        cs_n <= 1'b1;
        drive <= 1'b0;
        #100;
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the register-access sequencer.
// Assumes the host model owns the serial pins; notes queue expectations.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb;
    localparam [15:0] MAKER = 16'hC35A; // Arbitrary value
    logic clk;
    logic rst_n = 1'b0;
    wire cs_n, sclk, sdi, sdo, sdo_oe_n, partial_access_flag;
    wire [15:0] channel_code_word;
    wire [23:0] trim_word;
    logic [23:0] exp_q[$], got_q[$], g, e;
    logic [7:0] tx_q[$], rx_q[$];
    logic [15:0] rnd;
    logic [23:0] trm;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 1;
    sras_seq #(.MAKER_ID(MAKER)) sras_seq_i (.clk(clk), .rst_n(rst_n),
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .channel_code_word(channel_code_word),
        .trim_word(trim_word), .partial_access_flag(partial_access_flag));
    sras_host sras_host_i (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // Result watcher and hang guard
    // ****************************************
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (got_q.size() > 0)
        begin
            g = got_q.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
        end
        if (cyc == 30000)
        begin
            n_mismatch++;
            complete_run();
        end
    end
    task note(input logic [23:0] x, input logic [23:0] y);
        exp_q.push_back(x);
        got_q.push_back(y);
    endtask
    // Eight idle cycles let a commit or flag update land before looking
    task frame(input logic [7:0] ins);
        logic [7:0] r;
        rx_q = {};
        sras_host_i.start_frame();
        sras_host_i.xbyte(ins, r);
        foreach (tx_q[i])
        begin
            sras_host_i.xbyte(tx_q[i], r);
            rx_q.push_back(r);
        end
        sras_host_i.end_frame();
        tx_q = {};
        repeat (8) @(posedge clk);
    endtask
    task wr1(input logic [6:0] a, input logic [7:0] d);
        tx_q = '{d};
        frame({1'b0, a});
    endtask
    task rd(input logic [6:0] a, input int n);
        repeat (n) tx_q.push_back(8'h00);
        frame({1'b1, a});
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        note(24'h00_0000, trim_word);
        note(24'h00_0000, {channel_code_word, 7'h00, partial_access_flag});
        rd(7'h11, 2);
        note(24'h00_0020, {rx_q[0], rx_q[1]});
        rd(7'h01, 1);
        note(24'h00_0008, rx_q[0]);
        rd(7'h0D, 2);
        note({MAKER, 8'h00}, {rx_q[0], rx_q[1], 7'h00, partial_access_flag});
        repeat (3)
        begin
            rnd = 16'($random(seed));
            tx_q = '{rnd[15:8], rnd[7:0]};
            frame(8'h2A);
            note(rnd, channel_code_word);
        end
        rd(7'h0C, 1);
        note({MAKER[7:0], 1'b1}, {rx_q[0], partial_access_flag});
        wr1(7'h00, 8'h00);
        note(24'h00_0001, partial_access_flag);
        wr1(7'h11, 8'h04);
        note(24'h00_0000, partial_access_flag);
        wr1(7'h2A, 8'hA5);
        note({rnd, 1'b1}, {channel_code_word, partial_access_flag});
        wr1(7'h11, 8'h04);
        trm = 24'($random(seed));
        tx_q = '{trm[23:16], trm[15:8], trm[7:0]};
        frame(8'h2D);
        note(trm, trim_word);
        wr1(7'h00, 8'h20);
        tx_q = '{rnd[7:0] ^ 8'hFF, rnd[15:8]};
        frame(8'h29);
        note({rnd, 1'b1}, {channel_code_word, partial_access_flag});
        wr1(7'h11, 8'h04);
        tx_q = '{8'h00, 8'h20, 8'h88};
        frame(8'h4B);
        tx_q = '{8'h00, 8'h01, 8'h08};
        frame(8'h81);
        note(24'h00_0088, rx_q[0]);
        rd(7'h01, 1);
        note(24'h00_0008, rx_q[0]);
        wr1(7'h00, 8'h00);
        // Loop count must survive its own frame's select rise
        wr1(7'h0F, 8'h04);
        wr1(7'h0E, 8'h02);
        tx_q = '{8'h11, 8'h22, 8'h33, 8'h44};
        frame(8'h2A);
        note(24'h00_3344, channel_code_word);
        wr1(7'h0F, 8'h00);
        rd(7'h0E, 1);
        note(24'h00_0000, rx_q[0]);
        wr1(7'h0F, 8'h04);
        wr1(7'h0E, 8'h02);
        rd(7'h0E, 1);
        note(24'h00_0002, rx_q[0]);
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule
